// ### hdl/icc_pkg.sv
// constants, types and capture buffer memory of the input capture channel
//==============================================================================
// Contract
// - idle-halt bit 13 stops channel in idle
// - bit 7 picks timer b or c
// - bits 6-5 set captures per interrupt
// - bit 4 read-only overflow flag
// - bit 3 shows buffer not empty
// - mode 111 is sleep/idle rising-edge wake interrupt
// - mode 110 unused, channel disabled
// - mode 101 captures every sixteenth rising edge
// - mode 100 captures every fourth rising edge
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 captures both edges
// - every-edge mode ignores captures-per-interrupt field
// - mode 000 switches the channel off
// - unimplemented control bits read zero
// - capture latches the full 16-bit count
// - buffer holds four 16-bit entries
package icc_pkg;

  //============================================================================
  // sizes and bus
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned APB_SW = 4;
  localparam int unsigned CTRL_W = 16;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_BUF = 12'h004;
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  //============================================================================
  // control word layout
  localparam int unsigned BIT_IDLE_HALT = 13;
  localparam int unsigned BIT_TIMEBASE = 7;
  localparam int unsigned BIT_CPI_LO = 5;
  localparam int unsigned BIT_OVF = 4;
  localparam int unsigned BIT_BNE = 3;
  localparam int unsigned BIT_MODE_LO = 0;
  localparam logic [CTRL_W-1:0] CTRL_RSVD_MASK = 16'hDF00;

  //============================================================================
  // capture modes and prescaler
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_RISE = 3'h3;
  localparam logic [2:0] MODE_RISE4 = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE = 3'h7;
  localparam logic [3:0] PRESC_LAST_4 = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hF;

  //============================================================================
  // types
  typedef struct packed {
    logic idle_halt;
    logic timebase_select;
    logic [1:0] captures_per_irq;
    logic [2:0] capture_mode_select;
  } icc_ctrl_t;

  localparam icc_ctrl_t CTRL_RESET = 7'h00;

  typedef enum logic [0:0] {PH_WAIT, PH_DONE} icc_apb_ph_t;

  // control word as software sees it; reserved bits stay zero
  function automatic logic [CTRL_W-1:0] icc_pack_ctrl(icc_ctrl_t c, logic ovf, logic bne);
    logic [CTRL_W-1:0] w;
    w = '0;
    w[BIT_IDLE_HALT] = c.idle_halt;
    w[BIT_TIMEBASE] = c.timebase_select;
    w[BIT_CPI_LO +: 2] = c.captures_per_irq;
    w[BIT_OVF] = ovf;
    w[BIT_BNE] = bne;
    w[BIT_MODE_LO +: 3] = c.capture_mode_select;
    return w;
  endfunction

  function automatic icc_ctrl_t icc_unpack_ctrl(logic [CTRL_W-1:0] w);
    icc_ctrl_t c;
    c.idle_halt = w[BIT_IDLE_HALT];
    c.timebase_select = w[BIT_TIMEBASE];
    c.captures_per_irq = w[BIT_CPI_LO +: 2];
    c.capture_mode_select = w[BIT_MODE_LO +: 3];
    return c;
  endfunction

endpackage // icc_pkg

//==============================================================================
// capture buffer storage with registered, write-through read port
module icc_fifo_mem
  import icc_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port, address is the next read pointer
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [WIDTH-1:0] rd_q;
  logic [WIDTH-1:0] rd_d;

  // write-through keeps the output right when a value lands in an empty buffer
  always_comb begin
    mem_d = mem_q;
    if (wr_en_in) begin
      mem_d[wr_addr_in] = wr_data_in;
    end
    if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
      rd_d = wr_data_in;
    end else begin
      rd_d = mem_q[rd_addr_in];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mem_q <= '{default: '0};
      rd_q <= '0;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data_out = rd_q;

endmodule // icc_fifo_mem

// ### hdl/icc_capture_channel.sv
// input capture channel: apb registers, pin edge detect, prescaler, capture buffer
//
// Added by the designer: the register offsets and the APB register port.
module icc_capture_channel
  import icc_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned TW = DATA_W
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [APB_DW-1:0] pwdata_in,
  input wire logic [APB_SW-1:0] pstrb_in,
  output logic [APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // capture pin and time bases
  input wire logic capture_input_pin_in,
  input wire logic [TW-1:0] timer_b_count_in,
  input wire logic [TW-1:0] timer_c_count_in,
  // cpu power state
  input wire logic cpu_idle_in,
  input wire logic cpu_sleep_in,
  // event towards the interrupt controller
  output logic capture_irq_out
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  //============================================================================
  // declarations
  logic pin_s1_q, pin_s1_d;
  logic pin_s2_q, pin_s2_d;
  logic pin_prev_q, pin_prev_d;
  logic rise_w, fall_w;
  icc_ctrl_t ctrl_q, ctrl_d;
  icc_ctrl_t wr_fields_w;
  logic [2:0] mode_w;
  logic [AW-1:0] wr_ptr_q, wr_ptr_d;
  logic [AW-1:0] rd_ptr_q, rd_ptr_d;
  logic [CW-1:0] count_q, count_d;
  logic ovf_q, ovf_d;
  logic [3:0] presc_q, presc_d;
  logic [1:0] irqcnt_q, irqcnt_d;
  logic irq_q, irq_d;
  logic halt_w, presc_hit_w, event_w, cap_w, full_w, bne_w;
  logic push_w, pop_w, flush_w;
  logic [TW-1:0] cap_value_w;
  logic [TW-1:0] buf_rdata_w;
  icc_apb_ph_t ph_q, ph_d;
  logic [APB_DW-1:0] prdata_q, prdata_d;
  logic acc_w, load_w, pready_w, hit_ctrl_w, hit_buf_w, wr_ctrl_w, rd_buf_w;

  //============================================================================
  // pin front end
  // two flops before any logic looks at the pin, a third for edge detection
  always_comb begin
    pin_s1_d = capture_input_pin_in;
    pin_s2_d = pin_s1_q;
    pin_prev_d = pin_s2_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_prev_q <= pin_prev_d;
    end
  end

  assign rise_w = pin_s2_q & ~pin_prev_q;
  assign fall_w = ~pin_s2_q & pin_prev_q;

  //============================================================================
  // apb slave
  // two access cycles: the first loads read data into a flop, the second answers
  assign acc_w = psel_in & penable_in;
  assign load_w = acc_w & (ph_q == PH_WAIT);
  assign pready_w = acc_w & (ph_q == PH_DONE);
  assign hit_ctrl_w = (paddr_in == ADDR_CTRL);
  assign hit_buf_w = (paddr_in == ADDR_BUF);
  assign wr_ctrl_w = pready_w & pwrite_in & hit_ctrl_w;
  assign rd_buf_w = pready_w & ~pwrite_in & hit_buf_w;
  assign wr_fields_w = icc_unpack_ctrl(pwdata_in[CTRL_W-1:0]);

  always_comb begin
    ph_d = load_w ? PH_DONE : PH_WAIT;
    prdata_d = prdata_q;
    if (load_w) begin
      prdata_d = '0;
      if (!pwrite_in && hit_ctrl_w) begin
        prdata_d[CTRL_W-1:0] = icc_pack_ctrl(ctrl_q, ovf_q, bne_w);
      end else if (!pwrite_in && hit_buf_w && bne_w) begin
        prdata_d[TW-1:0] = buf_rdata_w; // oldest entry
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ph_q <= PH_WAIT;
      prdata_q <= '0;
    end else begin
      ph_q <= ph_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata_out = prdata_q;
  assign pready_out = pready_w;
  assign pslverr_out = pready_w & ~(hit_ctrl_w | hit_buf_w);

  //============================================================================
  // event decode
  assign mode_w = ctrl_q.capture_mode_select;
  // sleep stops the channel clock in a real part, so normal captures stop too
  assign halt_w = (ctrl_q.idle_halt & cpu_idle_in) | cpu_sleep_in;
  assign presc_hit_w = ((mode_w == MODE_RISE4) && (presc_q == PRESC_LAST_4))
                     || ((mode_w == MODE_RISE16) && (presc_q == PRESC_LAST_16));

  // which pin activity counts as a capture in each mode
  always_comb begin
    unique case (mode_w)
      MODE_OFF: event_w = 1'b0;
      MODE_EVERY_EDGE: event_w = rise_w | fall_w;
      MODE_FALL: event_w = fall_w;
      MODE_RISE: event_w = rise_w;
      MODE_RISE4: event_w = rise_w & presc_hit_w;
      MODE_RISE16: event_w = rise_w & presc_hit_w;
      MODE_UNUSED: event_w = 1'b0;
      MODE_WAKE: event_w = 1'b0; // pin is only a wake source here
    endcase
  end

  assign cap_w = event_w & ~halt_w;
  assign full_w = (count_q == CW'(DEPTH));
  assign bne_w = (count_q != '0);
  assign push_w = cap_w & ~full_w; // full buffer drops the value
  assign pop_w = rd_buf_w & bne_w;
  assign flush_w = wr_ctrl_w & pstrb_in[LANE_LO] & (wr_fields_w.capture_mode_select == MODE_OFF);
  assign cap_value_w = ctrl_q.timebase_select ? timer_b_count_in : timer_c_count_in;

  //============================================================================
  // channel state: control, buffer pointers, prescaler, interrupt pacing
  always_comb begin
    ctrl_d = ctrl_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    presc_d = presc_q;
    irqcnt_d = irqcnt_q;
    irq_d = 1'b0;
    // byte lanes: low lane holds mode, pacing and timebase, high lane idle halt
    if (wr_ctrl_w && pstrb_in[LANE_LO]) begin
      ctrl_d.timebase_select = wr_fields_w.timebase_select;
      ctrl_d.captures_per_irq = wr_fields_w.captures_per_irq;
      ctrl_d.capture_mode_select = wr_fields_w.capture_mode_select;
    end
    if (wr_ctrl_w && pstrb_in[LANE_HI]) begin
      ctrl_d.idle_halt = wr_fields_w.idle_halt;
    end
    // buffer pointers wrap naturally, so depth must be a power of two
    if (push_w) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    if (pop_w) begin
      rd_ptr_d = rd_ptr_q + 1'b1;
    end
    count_d = count_q + CW'(push_w) - CW'(pop_w);
    // a set wins over the clear that switching off performs
    ovf_d = (cap_w & full_w) | (ovf_q & ~flush_w);
    if (flush_w) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = '0;
    end
    // prescaler counts rising edges only in the divided modes
    if ((mode_w == MODE_RISE4) || (mode_w == MODE_RISE16)) begin
      if (rise_w && !halt_w) begin
        presc_d = presc_hit_w ? 4'h0 : presc_q + 4'h1;
      end
    end else begin
      presc_d = 4'h0;
    end
    // interrupt pacing; the wake mode ignores every other control bit
    if (mode_w == MODE_WAKE) begin
      irq_d = rise_w & (cpu_sleep_in | cpu_idle_in);
    end else if (cap_w) begin
      if ((mode_w == MODE_EVERY_EDGE) || (irqcnt_q == ctrl_q.captures_per_irq)) begin
        irq_d = 1'b1;
        irqcnt_d = 2'h0;
      end else begin
        irqcnt_d = irqcnt_q + 2'h1;
      end
    end
    // a new setting restarts both counters from a clean point
    if (wr_ctrl_w) begin
      presc_d = 4'h0;
      irqcnt_d = 2'h0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RESET;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ovf_q <= 1'b0;
      presc_q <= 4'h0;
      irqcnt_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      ovf_q <= ovf_d;
      presc_q <= presc_d;
      irqcnt_q <= irqcnt_d;
      irq_q <= irq_d;
    end
  end

  assign capture_irq_out = irq_q;

  //============================================================================
  // capture buffer storage, read at the next read pointer
  icc_fifo_mem #(
    .WIDTH(TW),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_buf (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .wr_en_in(push_w),
    .wr_addr_in(wr_ptr_q),
    .wr_data_in(cap_value_w),
    .rd_addr_in(rd_ptr_d),
    .rd_data_out(buf_rdata_w)
  );

  //============================================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // a clean slot: nothing else moves the buffer in this cycle
  sequence s_slot_free;
    !halt_w && !pop_w && !wr_ctrl_w && (count_q < CW'(DEPTH));
  endsequence

  sequence s_ctrl_read;
    load_w && !pwrite_in && hit_ctrl_w;
  endsequence

  property p_stores(logic trig);
    (trig ##0 s_slot_free) |=> (count_q == $past(count_q) + 1'b1);
  endproperty

  halt_in_idle_a: assert property (
    (ctrl_q.idle_halt && cpu_idle_in && mode_w != MODE_WAKE)
    |=> (count_q <= $past(count_q) && !capture_irq_out))
    else $error("capture seen while halted in idle");

  timebase_value_a: assert property (
    (push_w && count_q == '0 && !wr_ctrl_w)
    |=> (buf_rdata_w == ($past(ctrl_q.timebase_select) ? $past(timer_b_count_in)
                                                      : $past(timer_c_count_in))))
    else $error("captured value is not the selected timer count");

  irq_pacing_a: assert property (
    (cap_w && mode_w != MODE_EVERY_EDGE && !wr_ctrl_w)
    |=> (capture_irq_out == ($past(irqcnt_q) == $past(ctrl_q.captures_per_irq))))
    else $error("interrupt does not follow captures per interrupt");

  ovf_readonly_a: assert property (
    (wr_ctrl_w && !flush_w && !(cap_w && full_w)) |=> (ovf_q == $past(ovf_q)))
    else $error("software write changed overflow flag");

  bne_status_a: assert property (
    s_ctrl_read |=> (prdata_out[BIT_BNE] == ($past(count_q) != '0)))
    else $error("not-empty bit does not match buffer fill");

  wake_irq_a: assert property (
    (mode_w == MODE_WAKE && rise_w && (cpu_sleep_in || cpu_idle_in))
    |=> (capture_irq_out && count_q <= $past(count_q)))
    else $error("wake edge did not raise interrupt alone");

  disabled_a: assert property (
    (mode_w == MODE_OFF || mode_w == MODE_UNUSED)
    |=> (!capture_irq_out && count_q <= $past(count_q)))
    else $error("disabled channel captured");

  presc16_a: assert property (
    p_stores(mode_w == MODE_RISE16 && rise_w && presc_q == PRESC_LAST_16))
    else $error("sixteenth rising edge not captured");

  presc4_a: assert property (
    p_stores(mode_w == MODE_RISE4 && rise_w && presc_q == PRESC_LAST_4))
    else $error("fourth rising edge not captured");

  rise_capture_a: assert property (p_stores(mode_w == MODE_RISE && rise_w))
    else $error("rising edge not captured");

  fall_capture_a: assert property (p_stores(mode_w == MODE_FALL && fall_w))
    else $error("falling edge not captured");

  both_edge_capture_a: assert property (
    p_stores(mode_w == MODE_EVERY_EDGE && (rise_w || fall_w)))
    else $error("edge not captured in every-edge mode");

  every_edge_irq_a: assert property (
    (cap_w && mode_w == MODE_EVERY_EDGE && !wr_ctrl_w) |=> capture_irq_out)
    else $error("every-edge capture without interrupt");

  reserved_zero_a: assert property (
    s_ctrl_read |=> ((prdata_out[CTRL_W-1:0] & CTRL_RSVD_MASK) == '0))
    else $error("unimplemented control bits not zero");

  overflow_drop_a: assert property (
    (cap_w && full_w && !pop_w && !wr_ctrl_w) |=> (ovf_q && count_q == CW'(DEPTH)))
    else $error("capture into full buffer mishandled");

  pop_oldest_a: assert property (
    (rd_buf_w && count_q == CW'(1) && !push_w) |=> (!bne_w ##1 (!bne_w || $past(push_w))))
    else $error("last read did not empty the buffer");

endmodule // icc_capture_channel

// ### sim/icc_pin_timer_model.sv
// partner model: capture pin driver and two timer counts that freeze during each pulse burst
module icc_pin_timer_model
  import icc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // pin and time bases towards the channel
  // pin idles low between bursts
  output logic capture_input_pin_out = 1'b0,
  output logic [DATA_W-1:0] timer_b_count_out,
  output logic [DATA_W-1:0] timer_c_count_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic run_q = 1'b1;

  //============================================================================
  // time bases
  // distinct seeds and directions, so a swapped timebase shows at once
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      timer_b_count_out <= 16'hA000;
      timer_c_count_out <= 16'h0F0F;
    end else if (run_q) begin
      timer_b_count_out <= timer_b_count_out + 16'h0001;
      timer_c_count_out <= timer_c_count_out - 16'h0003;
    end
  end

  //============================================================================
  // pin stimulus
  // timers freeze during a burst so the captured count is known exactly;
  // pulses are 3 cycles high and 3 low, wider than the synchroniser needs
  task automatic pulses(input int n, output logic [DATA_W-1:0] vb,
                        output logic [DATA_W-1:0] vc);
    @(posedge clk_sys_in) run_q <= 1'b0;
    @(posedge clk_sys_in);
    vb = timer_b_count_out;
    vc = timer_c_count_out;
    repeat (n) begin
      capture_input_pin_out <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      capture_input_pin_out <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
    end
    // let the last detect and its interrupt pulse land
    repeat (4) @(posedge clk_sys_in);
    run_q <= 1'b1;
  endtask
endmodule // icc_pin_timer_model

// ### sim/icc_capture_channel_tb_top.sv
// self-checking bench for the input capture channel
module icc_capture_channel_tb_top
  import icc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst, psel, penable, pwrite, pin, idle, sleep, pready, pslverr, irq;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [APB_SW-1:0] strb;
  logic [DATA_W-1:0] tb_cnt, tc_cnt, vb, vc;
  logic err;
  int n_fail = 0;
  int checks_done = 0;
  int irq_cnt = 0;
  int base;

  //============================================================================
  // instances
  icc_capture_channel i_icc_capture_channel (
    .clk_sys_in(clk_sys), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(strb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .capture_input_pin_in(pin), .timer_b_count_in(tb_cnt), .timer_c_count_in(tc_cnt),
    .cpu_idle_in(idle), .cpu_sleep_in(sleep), .capture_irq_out(irq));

  icc_pin_timer_model i_icc_pin_timer_model (
    .clk_sys_in(clk_sys), .rst_in(rst), .capture_input_pin_out(pin),
    .timer_b_count_out(tb_cnt), .timer_c_count_out(tc_cnt));

  //============================================================================
  // clock, interrupt pulse counter, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // one-cycle pulses, so counting edges where it is high counts events
  always @(posedge clk_sys) if (irq === 1'b1) irq_cnt++;

  // whole run is under a thousand cycles; 40000 leaves ample margin
  initial begin
    #200000;
    n_fail++;
    results();
  end

  //============================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; waits an edge first so signals never change twice per step
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk_sys);
    penable <= 1'b1;
    // the slave sets the pace; only the watchdog ends a stuck wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic burst(input int n, input int exp_irq);
    base = irq_cnt;
    i_icc_pin_timer_model.pulses(n, vb, vc);
    chk(32'(irq_cnt - base), 32'(exp_irq));
  endtask

  //============================================================================
  // scenarios
  task automatic t_regs();
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_0000);
    apb(1, ADDR_CTRL, 32'hFFFF_FFFF);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_20E7);
    // high lane alone reaches only the idle-halt bit
    strb <= 4'h2;
    apb(1, ADDR_CTRL, 0);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_00E7);
    // low lane alone reaches mode, pacing and timebase
    strb <= 4'h1;
    apb(1, ADDR_CTRL, 32'h0000_2083);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_0083);
    strb <= 4'hF;
    apb(1, ADDR_BUF, 32'h0000_1234);
    apb(0, ADDR_BUF, 0);
    chk({rd[31:1], err}, 32'h0000_0000);
    apb(0, 12'h008, 0);
    chk({rd[31:1], err}, 32'h0000_0001);
    $display("register test done");
  endtask

  task automatic t_modes();
    int np[8] = '{4, 4, 4, 4, 8, 16, 4, 4};
    int ex[8] = '{0, 8, 4, 4, 2, 1, 0, 0};
    for (int m = 0; m < 8; m++) begin
      apb(1, ADDR_CTRL, 0);
      apb(1, ADDR_CTRL, 32'(m));
      burst(np[m], ex[m]);
    end
    $display("mode test done");
  endtask

  task automatic t_fifo();
    logic [DATA_W-1:0] q[$];
    apb(1, ADDR_CTRL, 0);
    apb(1, ADDR_CTRL, 32'h0000_0083);
    burst(1, 1);
    q.push_back(vb);
    apb(1, ADDR_CTRL, 32'h0000_0003);
    // field 00 signals every single capture, as dma use needs
    burst(4, 4);
    q.push_back(vc);
    q.push_back(vc);
    q.push_back(vc);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_001B);
    foreach (q[i]) begin
      apb(0, ADDR_BUF, 0);
      chk(rd, {16'h0000, q[i]});
    end
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_0013);
    apb(0, ADDR_BUF, 0);
    chk(rd, 32'h0000_0000);
    apb(1, ADDR_CTRL, 0);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_0000);
    $display("buffer test done");
  endtask

  task automatic t_cpi();
    apb(1, ADDR_CTRL, 32'h0000_0043);
    burst(6, 2);
    apb(1, ADDR_CTRL, 0);
    apb(1, ADDR_CTRL, 32'h0000_0061);
    burst(2, 4);
    $display("interrupt count test done");
  endtask

  task automatic t_power();
    apb(1, ADDR_CTRL, 0);
    idle <= 1'b1;
    apb(1, ADDR_CTRL, 32'h0000_2003);
    burst(2, 0);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_2003);
    apb(1, ADDR_CTRL, 32'h0000_0003);
    burst(2, 2);
    apb(1, ADDR_CTRL, 0);
    idle <= 1'b0;
    sleep <= 1'b1;
    apb(1, ADDR_CTRL, 32'h0000_20E7);
    burst(3, 3);
    apb(0, ADDR_CTRL, 0);
    chk(rd, 32'h0000_20E7);
    sleep <= 1'b0;
    $display("power state test done");
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  //============================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    strb = 4'hF;
    idle = 1'b0;
    sleep = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_fifo();
    t_cpi();
    t_power();
    results();
  end
endmodule // icc_capture_channel_tb_top
